// [dbt_top.sv]
// Two-queue bidirectional transceiver with pass-through select.
`timescale 1ns/1ps
`include "dbt_defs.svh"
module dbt_top
    import dbt_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  queue_a_reset_n,
    input  wire logic  queue_b_reset_n,
    input  wire logic  queue_a_load_clock,
    input  wire logic  queue_a_unload_clock,
    input  wire logic  queue_b_load_clock,
    input  wire logic  queue_b_unload_clock,
    input  wire logic  queue_a_offset_define_n,
    input  wire logic  queue_b_offset_define_n,
    input  wire logic  b_bus_source_select,
    input  wire logic  a_bus_source_select,
    input  wire logic  direction,
    input  wire logic  output_enable_n,
    input  dbt_word_t  side_a_data_in,
    output dbt_word_t  side_a_data_out,
    output logic       side_a_data_oe_n,
    input  dbt_word_t  side_b_data_in,
    output dbt_word_t  side_b_data_out,
    output logic       side_b_data_oe_n,
    output logic       queue_a_empty_n,
    output logic       queue_a_full_n,
    output logic       queue_a_half_flag,
    output logic       queue_a_near_limit_flag,
    output logic       queue_b_empty_n,
    output logic       queue_b_full_n,
    output logic       queue_b_half_flag,
    output logic       queue_b_near_limit_flag
);
    // Every pin but clk and rst_n is asynchronous to clk. Pulses on the load, unload
    // and define pins must each stay high and low for at least two
    // clk periods, or the edge may be missed.

    dbt_pins_t   pin_raw;
    dbt_pins_t   pin_meta;
    dbt_pins_t   pin_sync;
    dbt_pins_t   pin_prev;
    dbt_word_t   a_meta;
    dbt_word_t   a_sync;
    dbt_word_t   b_meta;
    dbt_word_t   b_sync;

    logic        a_load_rise;
    logic        a_unload_rise;
    logic        b_load_rise;
    logic        b_unload_rise;
    logic        a_def_fall;
    logic        b_def_fall;
    logic        a_queue_rst;
    logic        b_queue_rst;

    dbt_word_t   a_offset_staged;
    dbt_word_t   b_offset_staged;
    dbt_word_t   a_offset;
    dbt_word_t   b_offset;

    dbt_drive_t  drive;
    dbt_drive_t  next_drive;

    dbt_queue_if qa ();
    dbt_queue_if qb ();

    assign pin_raw[`DBT_PIN_A_LOAD]   = queue_a_load_clock;
    assign pin_raw[`DBT_PIN_A_UNLOAD] = queue_a_unload_clock;
    assign pin_raw[`DBT_PIN_B_LOAD]   = queue_b_load_clock;
    assign pin_raw[`DBT_PIN_B_UNLOAD] = queue_b_unload_clock;
    assign pin_raw[`DBT_PIN_A_DEF_N]  = queue_a_offset_define_n;
    assign pin_raw[`DBT_PIN_B_DEF_N]  = queue_b_offset_define_n;
    assign pin_raw[`DBT_PIN_A_RST_N]  = queue_a_reset_n;
    assign pin_raw[`DBT_PIN_B_RST_N]  = queue_b_reset_n;
    assign pin_raw[`DBT_PIN_A_SEL]    = b_bus_source_select;
    assign pin_raw[`DBT_PIN_B_SEL]    = a_bus_source_select;
    assign pin_raw[`DBT_PIN_DIR]      = direction;
    assign pin_raw[`DBT_PIN_OE_N]     = output_enable_n;

    // Control pins and data share the same two-stage delay, so the
    // word seen at a detected edge is the one sampled with it.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta <= `DBT_PIN_RST_VAL;
            pin_sync <= `DBT_PIN_RST_VAL;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_prev <= `DBT_PIN_RST_VAL;
        end else begin
            pin_prev <= pin_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            a_meta <= '0;
            a_sync <= '0;
        end else begin
            a_meta <= side_a_data_in;
            a_sync <= a_meta;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            b_meta <= '0;
            b_sync <= '0;
        end else begin
            b_meta <= side_b_data_in;
            b_sync <= b_meta;
        end
    end

    assign a_load_rise   = pin_sync[`DBT_PIN_A_LOAD] &&
                           !pin_prev[`DBT_PIN_A_LOAD];
    assign a_unload_rise = pin_sync[`DBT_PIN_A_UNLOAD] &&
                           !pin_prev[`DBT_PIN_A_UNLOAD];
    assign b_load_rise   = pin_sync[`DBT_PIN_B_LOAD] &&
                           !pin_prev[`DBT_PIN_B_LOAD];
    assign b_unload_rise = pin_sync[`DBT_PIN_B_UNLOAD] &&
                           !pin_prev[`DBT_PIN_B_UNLOAD];
    assign a_def_fall    = !pin_sync[`DBT_PIN_A_DEF_N] &&
                           pin_prev[`DBT_PIN_A_DEF_N];
    assign b_def_fall    = !pin_sync[`DBT_PIN_B_DEF_N] &&
                           pin_prev[`DBT_PIN_B_DEF_N];

    // Each direction resets on its own pin or on the system reset.
    assign a_queue_rst = !rst_n || !pin_sync[`DBT_PIN_A_RST_N];
    assign b_queue_rst = !rst_n || !pin_sync[`DBT_PIN_B_RST_N];

    // Queue A takes words from the A side and empties toward B.
    assign qa.rst       = a_queue_rst;
    assign qa.load      = a_load_rise;
    assign qa.unload    = a_unload_rise;
    assign qa.load_word = a_sync;

    // Queue B takes words from the B side and empties toward A.
    assign qb.rst       = b_queue_rst;
    assign qb.load      = b_load_rise;
    assign qb.unload    = b_unload_rise;
    assign qb.load_word = b_sync;

    dbt_queue #(
        .DEPTH (`DBT_DEPTH)
    ) u_queue_a (
        .clk (clk),
        .q   (qa)
    );

    dbt_queue #(
        .DEPTH (`DBT_DEPTH)
    ) u_queue_b (
        .clk (clk),
        .q   (qb)
    );

    // The staged offset survives queue resets, so a define pin held low
    // keeps the same offset for the next reset cycle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            a_offset_staged <= `DBT_DEF_OFFSET;
        end else if (a_def_fall) begin
            a_offset_staged <= a_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            b_offset_staged <= `DBT_DEF_OFFSET;
        end else if (b_def_fall) begin
            b_offset_staged <= b_sync;
        end
    end

    // The offset in force is reloaded on every cycle of queue reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            a_offset <= `DBT_DEF_OFFSET;
        end else if (a_queue_rst) begin
            if (pin_sync[`DBT_PIN_A_DEF_N]) begin
                a_offset <= `DBT_DEF_OFFSET;
            end else begin
                a_offset <= a_offset_staged;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            b_offset <= `DBT_DEF_OFFSET;
        end else if (b_queue_rst) begin
            if (pin_sync[`DBT_PIN_B_DEF_N]) begin
                b_offset <= `DBT_DEF_OFFSET;
            end else begin
                b_offset <= b_offset_staged;
            end
        end
    end

    // Flags follow the count one clk later.
    always_ff @(posedge clk) begin
        if (a_queue_rst) begin
            queue_a_empty_n <= 1'b1;
            queue_a_full_n  <= 1'b1;
        end else begin
            queue_a_empty_n <= (qa.count != '0);
            queue_a_full_n  <= (qa.count != `DBT_FULL_COUNT);
        end
    end

    always_ff @(posedge clk) begin
        if (a_queue_rst) begin
            queue_a_half_flag <= 1'b0;
        end else begin
            queue_a_half_flag <= (qa.count >= `DBT_HALF_COUNT);
        end
    end

    always_ff @(posedge clk) begin
        if (a_queue_rst) begin
            queue_a_near_limit_flag <= 1'b1;
        end else begin
            queue_a_near_limit_flag <=
                (qa.count <= {2'h0, a_offset}) ||
                (qa.count >= (`DBT_FULL_COUNT - {2'h0, a_offset}));
        end
    end

    always_ff @(posedge clk) begin
        if (b_queue_rst) begin
            queue_b_empty_n <= 1'b1;
            queue_b_full_n  <= 1'b1;
        end else begin
            queue_b_empty_n <= (qb.count != '0);
            queue_b_full_n  <= (qb.count != `DBT_FULL_COUNT);
        end
    end

    always_ff @(posedge clk) begin
        if (b_queue_rst) begin
            queue_b_half_flag <= 1'b0;
        end else begin
            queue_b_half_flag <= (qb.count >= `DBT_HALF_COUNT);
        end
    end

    always_ff @(posedge clk) begin
        if (b_queue_rst) begin
            queue_b_near_limit_flag <= 1'b1;
        end else begin
            queue_b_near_limit_flag <=
                (qb.count <= {2'h0, b_offset}) ||
                (qb.count >= (`DBT_FULL_COUNT - {2'h0, b_offset}));
        end
    end

    // Bus data is chosen and then registered; a plain mux would let
    // the select and data race and show a wrong word for a moment.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            side_b_data_out <= '0;
        end else if (pin_sync[`DBT_PIN_A_SEL]) begin
            side_b_data_out <= qa.head_word;
        end else begin
            side_b_data_out <= a_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            side_a_data_out <= '0;
        end else if (pin_sync[`DBT_PIN_B_SEL]) begin
            side_a_data_out <= qb.head_word;
        end else begin
            side_a_data_out <= b_sync;
        end
    end

    always_comb begin
        next_drive = DRIVE_NONE;
        case ({pin_sync[`DBT_PIN_OE_N], pin_sync[`DBT_PIN_DIR]})
            2'h0: begin
                next_drive = DRIVE_A;
            end
            2'h1: begin
                next_drive = DRIVE_B;
            end
            default: begin
                next_drive = DRIVE_NONE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive <= DRIVE_NONE;
        end else begin
            drive <= next_drive;
        end
    end

    assign side_a_data_oe_n = (drive != DRIVE_A);
    assign side_b_data_oe_n = (drive != DRIVE_B);
endmodule

// [dbt_defs.svh]
// Constants for the dual-queue bidirectional transceiver.
// Behaviour
// - Two queues of 1024 nine-bit words, A to B and B to A.
// - Queue A near flag high at count <= offset or >= 1024 - offset.
// - Queue A near flag low between offset + 1 and 1023 - offset.
// - Queue B near flag uses same thresholds with its own offset.
// - Falling A define input captures A data as queue A offset.
// - Falling B define input captures B data as queue B offset.
// - Empty flag low while queue holds nothing, high otherwise.
// - Full flag low while queue holds maximum count, high otherwise.
// - Half flag high at 512 or more words, low at 511 or fewer.
// - Load clock rising edge writes that side's data into its queue.
// - Load edge while full is ignored, contents unchanged.
// - Queue A unload edge advances oldest A word onto B bus.
// - Queue B unload edge advances oldest B word onto A bus.
// - Unload edge while empty is ignored, contents unchanged.
// - Output enable high drives neither bus; both are inputs.
// - Enable low, direction high drives B bus, A bus released.
// - Enable low, direction low drives A bus, B bus released.
// - Queue reset sets empty, full and near flags high.
// - Source select low picks live data, high picks stored data.
// - Switching live and stored data gives no output glitch.
// - Offset applied at reset; define high through reset gives 256.
// - A-to-B select feeds B bus; B-to-A select feeds A bus.
`ifndef DBT_DEFS_SVH
`define DBT_DEFS_SVH
`define DBT_WORD_W       9
`define DBT_DEPTH        1024
`define DBT_COUNT_W      11
`define DBT_FULL_COUNT   11'h400
`define DBT_HALF_COUNT   11'h200
`define DBT_DEF_OFFSET   9'h100
`define DBT_PIN_W        12
`define DBT_PIN_A_LOAD   0
`define DBT_PIN_A_UNLOAD 1
`define DBT_PIN_B_LOAD   2
`define DBT_PIN_B_UNLOAD 3
`define DBT_PIN_A_DEF_N  4
`define DBT_PIN_B_DEF_N  5
`define DBT_PIN_A_RST_N  6
`define DBT_PIN_B_RST_N  7
`define DBT_PIN_A_SEL    8
`define DBT_PIN_B_SEL    9
`define DBT_PIN_DIR      10
`define DBT_PIN_OE_N     11
`define DBT_PIN_RST_VAL  12'h8f0
`endif

// [dbt_pkg.sv]
// Types shared by the transceiver modules.
package dbt_pkg;
`include "dbt_defs.svh"
    typedef logic [`DBT_WORD_W-1:0]  dbt_word_t;
    typedef logic [`DBT_COUNT_W-1:0] dbt_count_t;
    typedef logic [`DBT_PIN_W-1:0]   dbt_pins_t;
    typedef enum logic [1:0] {
        DRIVE_NONE,
        DRIVE_A,
        DRIVE_B
    } dbt_drive_t;
endpackage

// [dbt_queue_if.sv]
// Request and status bundle between the top and one queue.
`timescale 1ns/1ps
interface dbt_queue_if;
    import dbt_pkg::*;
    logic       rst;
    logic       load;
    logic       unload;
    dbt_word_t  load_word;
    dbt_word_t  head_word;
    dbt_count_t count;
    modport ctrl (
        output rst,
        output load,
        output unload,
        output load_word,
        input  head_word,
        input  count
    );
    modport queue (
        input  rst,
        input  load,
        input  unload,
        input  load_word,
        output head_word,
        output count
    );
endinterface

// [dbt_queue.sv]
// One storage queue with its own word count.
`timescale 1ns/1ps
`include "dbt_defs.svh"
module dbt_queue
    import dbt_pkg::*;
#(
    parameter int DEPTH = `DBT_DEPTH
) (
    input wire logic clk,
    dbt_queue_if.queue q
);
    localparam int AW = $clog2(DEPTH);
    localparam dbt_count_t FULL_COUNT = dbt_count_t'(DEPTH);

    dbt_word_t       mem [DEPTH];
    logic [AW-1:0]   wr_ptr;
    logic [AW-1:0]   rd_ptr;
    logic            do_load;
    logic            do_unload;

    assign do_load   = q.load && (q.count != FULL_COUNT);
    assign do_unload = q.unload && (q.count != '0);

    // The array has no reset so that it maps onto block memory.
    always_ff @(posedge clk) begin
        if (do_load) begin
            mem[wr_ptr] <= q.load_word;
        end
    end

    always_ff @(posedge clk) begin
        if (q.rst) begin
            wr_ptr <= '0;
        end else if (do_load) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (q.rst) begin
            rd_ptr <= '0;
        end else if (do_unload) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (q.rst) begin
            q.count <= '0;
        end else if (do_load && !do_unload) begin
            q.count <= q.count + 1'b1;
        end else if (do_unload && !do_load) begin
            q.count <= q.count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (q.rst) begin
            q.head_word <= '0;
        end else if (do_unload) begin
            q.head_word <= mem[rd_ptr];
        end
    end
endmodule

// [dbt_top_props.sv]
// Concurrent checks on the transceiver top-level ports.
`timescale 1ns/1ps
module dbt_top_props
    import dbt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic b_bus_source_select,
    input wire logic a_bus_source_select,
    input wire logic direction,
    input wire logic output_enable_n,
    input dbt_word_t side_a_data_in,
    input dbt_word_t side_a_data_out,
    input wire logic side_a_data_oe_n,
    input dbt_word_t side_b_data_in,
    input dbt_word_t side_b_data_out,
    input wire logic side_b_data_oe_n,
    input wire logic queue_a_empty_n,
    input wire logic queue_a_full_n,
    input wire logic queue_a_half_flag,
    input wire logic queue_a_near_limit_flag,
    input wire logic queue_b_empty_n,
    input wire logic queue_b_full_n,
    input wire logic queue_b_half_flag,
    input wire logic queue_b_near_limit_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Five cycles cover the two-flop sync plus the output register.
    sequence s_off;
        output_enable_n[*5];
    endsequence
    sequence s_drive_b;
        (!output_enable_n && direction)[*5];
    endsequence
    sequence s_drive_a;
        (!output_enable_n && !direction)[*5];
    endsequence
    sequence s_live_b;
        (!b_bus_source_select && $stable(side_a_data_in))[*6];
    endsequence
    sequence s_live_a;
        (!a_bus_source_select && $stable(side_b_data_in))[*6];
    endsequence
    oe_idle_a: assert property (s_off |->
        side_a_data_oe_n && side_b_data_oe_n) else $error("Bus driven");
    drive_b_a: assert property (s_drive_b |->
        !side_b_data_oe_n && side_a_data_oe_n) else $error("B drive");
    drive_a_a: assert property (s_drive_a |->
        !side_a_data_oe_n && side_b_data_oe_n) else $error("A drive");
    one_driver_a: assert property (
        side_a_data_oe_n || side_b_data_oe_n) else $error("Both driven");
    a_empty_flags_a: assert property (!queue_a_empty_n |->
        queue_a_full_n && !queue_a_half_flag && queue_a_near_limit_flag)
        else $error("A empty flags");
    a_full_flags_a: assert property (!queue_a_full_n |->
        queue_a_empty_n && queue_a_half_flag && queue_a_near_limit_flag)
        else $error("A full flags");
    b_empty_flags_a: assert property (!queue_b_empty_n |->
        queue_b_full_n && !queue_b_half_flag && queue_b_near_limit_flag)
        else $error("B empty flags");
    live_b_a: assert property (s_live_b |->
        side_b_data_out == side_a_data_in) else $error("Live B data");
    live_a_a: assert property (s_live_a |->
        side_a_data_out == side_b_data_in) else $error("Live A data");
endmodule

bind dbt_top dbt_top_props u_props (
    .clk(clk), .rst_n(rst_n), .direction(direction),
    .b_bus_source_select(b_bus_source_select),
    .a_bus_source_select(a_bus_source_select),
    .output_enable_n(output_enable_n),
    .side_a_data_in(side_a_data_in), .side_a_data_out(side_a_data_out),
    .side_a_data_oe_n(side_a_data_oe_n), .side_b_data_in(side_b_data_in),
    .side_b_data_out(side_b_data_out), .side_b_data_oe_n(side_b_data_oe_n),
    .queue_a_empty_n(queue_a_empty_n), .queue_a_full_n(queue_a_full_n),
    .queue_a_half_flag(queue_a_half_flag),
    .queue_a_near_limit_flag(queue_a_near_limit_flag),
    .queue_b_empty_n(queue_b_empty_n), .queue_b_full_n(queue_b_full_n),
    .queue_b_half_flag(queue_b_half_flag),
    .queue_b_near_limit_flag(queue_b_near_limit_flag));

// [dbt_bus_masters.sv]
// Bus masters on both sides, with the level each bus settles to.
`timescale 1ns/1ps
module dbt_bus_masters
    import dbt_pkg::*;
(
    input  dbt_word_t a_host,
    input  dbt_word_t b_host,
    input  dbt_word_t a_dev,
    input  wire logic a_dev_oe_n,
    input  dbt_word_t b_dev,
    input  wire logic b_dev_oe_n,
    output dbt_word_t a_bus,
    output dbt_word_t b_bus
);
    // A master drives only while the device lets go, so no contention.
    assign a_bus = a_dev_oe_n ? a_host : a_dev;
    assign b_bus = b_dev_oe_n ? b_host : b_dev;
endmodule

// [dbt_top_bench.sv]
// Self-checking bench for the two-queue transceiver.
`timescale 1ns/1ps
module dbt_top_bench
    import dbt_pkg::*;
;
    logic       clk;
    logic       rst_n = 1'b0;
    logic [3:0] ck = 4'h0;
    logic [1:0] rq = 2'b00;
    logic [1:0] dfn = 2'b11;
    logic       sel_a = 1'b0;
    logic       sel_b = 1'b0;
    logic       dir = 1'b0;
    logic       oe_n = 1'b1;
    dbt_word_t  md [2] = '{9'h000, 9'h000};
    dbt_word_t  a_in;
    dbt_word_t  b_in;
    dbt_word_t  a_out;
    dbt_word_t  b_out;
    logic       a_oe_n;
    logic       b_oe_n;
    logic [3:0] fa;
    logic [3:0] fb;
    dbt_word_t  expq [2][$];
    dbt_word_t  last [2] = '{9'h000, 9'h000};
    int         cnt [2] = '{0, 0};
    int         off [2] = '{256, 256};
    int         fails = 0;
    int         checked = 0;

    dbt_top dut (
        .clk(clk), .rst_n(rst_n),
        .queue_a_reset_n(rq[0]), .queue_b_reset_n(rq[1]),
        .queue_a_load_clock(ck[0]), .queue_a_unload_clock(ck[1]),
        .queue_b_load_clock(ck[2]), .queue_b_unload_clock(ck[3]),
        .queue_a_offset_define_n(dfn[0]), .queue_b_offset_define_n(dfn[1]),
        .b_bus_source_select(sel_b), .a_bus_source_select(sel_a),
        .direction(dir), .output_enable_n(oe_n),
        .side_a_data_in(a_in), .side_a_data_out(a_out),
        .side_a_data_oe_n(a_oe_n), .side_b_data_in(b_in),
        .side_b_data_out(b_out), .side_b_data_oe_n(b_oe_n),
        .queue_a_empty_n(fa[3]), .queue_a_full_n(fa[2]),
        .queue_a_half_flag(fa[1]), .queue_a_near_limit_flag(fa[0]),
        .queue_b_empty_n(fb[3]), .queue_b_full_n(fb[2]),
        .queue_b_half_flag(fb[1]), .queue_b_near_limit_flag(fb[0]));

    dbt_bus_masters u_bus (
        .a_host(md[0]), .b_host(md[1]), .a_dev(a_out), .a_dev_oe_n(a_oe_n),
        .b_dev(b_out), .b_dev_oe_n(b_oe_n), .a_bus(a_in), .b_bus(b_in));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string n, input logic [8:0] seen,
                       input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Pins pass a two-flop sync, so each level is held three cycles.
    task automatic pulse(input int k);
        ck[k] = 1'b1;
        cyc(3);
        ck[k] = 1'b0;
        cyc(3);
    endtask

    task automatic flags(input int s);
        int c;
        int o;
        c = cnt[s];
        o = off[s];
        chk("flags", 9'(s ? fb : fa), 9'({c != 0, c != 1024, c >= 512,
            c <= o || c >= 1024 - o}));
    endtask

    task automatic load(input int s, input dbt_word_t w);
        md[s] = w;
        pulse(2 * s);
        if (cnt[s] < 1024) begin
            expq[s].push_back(w);
            cnt[s]++;
        end
        flags(s);
    endtask

    task automatic unload(input int s);
        pulse(2 * s + 1);
        if (cnt[s] > 0) begin
            last[s] = expq[s].pop_front();
            cnt[s]--;
        end
        chk("head", s ? a_out : b_out, last[s]);
        flags(s);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        cyc(5);
        rst_n = 1'b1;
        rq = 2'b11;
        cyc(8);
        flags(0);
        flags(1);
        $display("reset flags test done");
        md[0] = 9'h005;
        cyc(1);
        dfn[0] = 1'b0;
        cyc(4);
        rq[0] = 1'b0;
        cyc(4);
        chk("reset flags", 9'(fa), 9'h00d);
        rq[0] = 1'b1;
        off[0] = 5;
        cyc(8);
        for (int i = 0; i < 1025; i++) load(0, 9'(i) ^ 9'h0a5);
        $display("queue A fill test done");
        sel_b = 1'b1;
        dir = 1'b1;
        oe_n = 1'b0;
        cyc(6);
        chk("drive", 9'({a_oe_n, b_oe_n}), 9'h002);
        for (int i = 0; i < 1025; i++) unload(0);
        $display("queue A drain test done");
        oe_n = 1'b1;
        md[1] = 9'h0f0;
        cyc(4);
        dfn[1] = 1'b0;
        cyc(4);
        dfn[1] = 1'b1;
        cyc(4);
        rq[1] = 1'b0;
        cyc(4);
        chk("reset flags", 9'(fb), 9'h00d);
        rq[1] = 1'b1;
        cyc(8);
        for (int i = 0; i < 258; i++) load(1, 9'h1ff - 9'(i));
        sel_a = 1'b1;
        dir = 1'b0;
        oe_n = 1'b0;
        cyc(6);
        chk("drive", 9'({a_oe_n, b_oe_n}), 9'h001);
        for (int i = 0; i < 259; i++) unload(1);
        md[1] = 9'h002;
        cyc(1);
        dfn[1] = 1'b0;
        cyc(4);
        rq[1] = 1'b0;
        cyc(4);
        rq[1] = 1'b1;
        off[1] = 2;
        cyc(8);
        for (int i = 0; i < 3; i++) load(1, 9'(i));
        $display("queue B test done");
        sel_a = 1'b0;
        sel_b = 1'b0;
        oe_n = 1'b1;
        md[0] = 9'h13c;
        md[1] = 9'h0c3;
        cyc(8);
        chk("live b", b_out, md[0]);
        chk("live a", a_out, md[1]);
        chk("drive", 9'({a_oe_n, b_oe_n}), 9'h003);
        $display("live data test done");
        close_out;
    end

    // The tests need some 16000 cycles; the limit leaves wide margin.
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        close_out;
    end
endmodule
